// [verilog/gpc_port.sv]
// pin configuration port: function routing, weak pulls, wake detection, axi4-lite slave
// assumes pad inputs are asynchronous and peripheral signals share clk_sys
`timescale 1ns/1ps
`include "gpc_map.svh"

module gpc_port
   import gpc_pkg::*;
#(
   parameter logic [`GPC_PINS-1:0] A_MAP = 16'hffff,
   parameter logic [`GPC_PINS-1:0] B_MAP = 16'hffff
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output      logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output      logic                 s_axi_wready,
   output      logic [1:0]           s_axi_bresp,
   output      logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output      logic                 s_axi_arready,
   output      logic [31:0]          s_axi_rdata,
   output      logic [1:0]           s_axi_rresp,
   output      logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [`GPC_PINS-1:0] pad_in,
   output      logic [`GPC_PINS-1:0] pad_out,
   output      logic [`GPC_PINS-1:0] pad_oe_n,
   output      logic [`GPC_PINS-1:0] pull_en,
   output      logic [`GPC_PINS-1:0] pull_up,
   input  wire logic [`GPC_PINS-1:0] periph_a_oe,
   input  wire logic [`GPC_PINS-1:0] periph_a_out,
   output      logic [`GPC_PINS-1:0] periph_a_in,
   input  wire logic [`GPC_PINS-1:0] periph_b_oe,
   input  wire logic [`GPC_PINS-1:0] periph_b_out,
   output      logic [`GPC_PINS-1:0] periph_b_in,
   output      logic [`GPC_PINS-1:0] wake_in,
   output      logic [`GPC_PINS-1:0] wake_req,
   output      logic                 irq
);

   gpc_state_t r_reg;
   gpc_state_t r_next;

   gpc_word_t drive;
   gpc_word_t drive_val;

   ////////////////////////////////////////////////////////////////////////////////
   // per-pin routing

   for (genvar i = 0; i < `GPC_PINS; i++) begin : g_pin
      logic use_b;
      logic a_on;
      logic b_on;
      // select only counts while the function is enabled
      assign use_b = r_reg.fen[i] & r_reg.fsel[i];                           // [R5] [R8]
      // unmapped table entries neither drive nor see the pad
      assign a_on  = r_reg.fen[i] & ~use_b & A_MAP[i];                        // [R7]
      assign b_on  = use_b & B_MAP[i];                                        // [R7]
      always_comb begin
         if (!r_reg.fen[i]) begin
            drive[i]     = r_reg.dir[i];                                      // [R2] [R16]
            drive_val[i] = r_reg.dout[i];                                     // [R2]
         end else begin
            drive[i]     = (a_on & periph_a_oe[i]) | (b_on & periph_b_oe[i]); // [R3]
            drive_val[i] = (a_on & periph_a_out[i]) | (b_on & periph_b_out[i]);
         end
      end
      assign pad_oe_n[i]    = ~drive[i];
      assign pad_out[i]     = drive_val[i];
      // pull follows the buffer state in either mode
      assign pull_en[i]     = r_reg.wpu[i] & ~drive[i];                       // [R9] [R10]
      assign pull_up[i]     = r_reg.wpu[i] & r_reg.pdr[i];                    // [R12]
      assign periph_a_in[i] = a_on & r_reg.pin[i];
      assign periph_b_in[i] = b_on & r_reg.pin[i];
      assign wake_in[i]     = r_reg.ien[i] & r_reg.pin[i];                    // [R1]
      assign wake_req[i]    = r_reg.ien[i] & ~(r_reg.pin[i] ^ r_reg.dout[i]); // [R14]
   end

   assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

   ////////////////////////////////////////////////////////////////////////////////
   // bus handshakes

   assign s_axi_awready = ~r_reg.aw_got & ~r_reg.bvalid;
   assign s_axi_wready  = ~r_reg.w_got & ~r_reg.bvalid;
   assign s_axi_arready = ~r_reg.rvalid;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rdata   = r_reg.rdata;
   assign s_axi_rresp   = r_reg.rresp;

   function automatic gpc_word_t merge(gpc_word_t old, logic [31:0] d, logic [3:0] s);
      gpc_word_t v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      gpc_word_t clr;
      gpc_word_t rd;
      logic      hit;
      clr    = '0;
      rd     = '0;
      hit    = 1'b1;
      r_next = r_reg;

      // three-stage sync; a change is taken once the last two agree
      r_next.sync1 = pad_in;
      r_next.sync2 = r_reg.sync1;
      r_next.sync3 = r_reg.sync2;
      for (int k = 0; k < `GPC_PINS; k++) begin
         if (r_reg.sync2[k] == r_reg.sync3[k]) begin
            r_next.pin[k] = r_reg.sync3[k];
         end
      end

      if (s_axi_awvalid && s_axi_awready) begin
         r_next.aw_got = 1'b1;
         r_next.wa     = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_next.w_got = 1'b1;
         r_next.wd    = s_axi_wdata;
         r_next.ws    = s_axi_wstrb;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end

      if (r_reg.aw_got && r_reg.w_got) begin
         r_next.aw_got = 1'b0;
         r_next.w_got  = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = `GPC_RESP_OKAY;
         unique case ({r_reg.wa[7:2], 2'b00})
            `GPC_OFF_FEN:      r_next.fen      = merge(r_reg.fen, r_reg.wd, r_reg.ws);   // [R17]
            `GPC_OFF_DIR:      r_next.dir      = merge(r_reg.dir, r_reg.wd, r_reg.ws);
            `GPC_OFF_DOUT:     r_next.dout     = merge(r_reg.dout, r_reg.wd, r_reg.ws);
            `GPC_OFF_WPU:      r_next.wpu      = merge(r_reg.wpu, r_reg.wd, r_reg.ws);
            `GPC_OFF_FSEL:     r_next.fsel     = merge(r_reg.fsel, r_reg.wd, r_reg.ws);
            `GPC_OFF_IEN:      r_next.ien      = merge(r_reg.ien, r_reg.wd, r_reg.ws);
            `GPC_OFF_PDR:      r_next.pdr      = merge(r_reg.pdr, r_reg.wd, r_reg.ws);
            `GPC_OFF_IRQ_MASK: r_next.irq_mask = merge(r_reg.irq_mask, r_reg.wd, r_reg.ws);
            `GPC_OFF_IRQ_STAT: clr             = merge('0, r_reg.wd, r_reg.ws);
            `GPC_OFF_DIN:      ;
            default:           r_next.bresp    = `GPC_RESP_SLVERR;
         endcase
      end

      // sticky wake events; a new event beats a clear in the same cycle
      r_next.wake_prev = wake_req;
      r_next.irq_stat  = (r_reg.irq_stat & ~clr) | (wake_req & ~r_reg.wake_prev);

      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         unique case ({s_axi_araddr[7:2], 2'b00})
            `GPC_OFF_FEN:      rd = r_reg.fen;                                            // [R17]
            `GPC_OFF_DIR:      rd = r_reg.dir;
            `GPC_OFF_DIN:      rd = r_reg.pin;
            `GPC_OFF_DOUT:     rd = r_reg.dout;
            `GPC_OFF_WPU:      rd = r_reg.wpu;
            `GPC_OFF_FSEL:     rd = r_reg.fsel;
            `GPC_OFF_IEN:      rd = r_reg.ien;
            `GPC_OFF_PDR:      rd = r_reg.pdr;
            `GPC_OFF_IRQ_STAT: rd = r_reg.irq_stat;
            `GPC_OFF_IRQ_MASK: rd = r_reg.irq_mask;
            default:           hit = 1'b0;
         endcase
         r_next.rvalid = 1'b1;
         r_next.rdata  = {16'h0000, rd};
         r_next.rresp  = hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r_reg          <= '0;
         r_reg.fen      <= `GPC_RST_ZERO;                                     // [R4]
         r_reg.wpu      <= `GPC_RST_ZERO;                                     // [R11]
         r_reg.pdr      <= `GPC_RST_PDR;                                      // [R13]
         r_reg.ien      <= `GPC_RST_ZERO;                                     // [R15]
         r_reg.dir      <= `GPC_RST_ZERO;                                     // [R16]
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_fen_commit;
      r_reg.aw_got && r_reg.w_got && r_reg.wa == `GPC_OFF_FEN && r_reg.ws[1:0] == 2'b11;
   endsequence

   chk_gpio_drive: assert property ( // [R2]
      (r_reg.fen == 16'h0000) |-> (pad_oe_n == ~r_reg.dir && pad_out == r_reg.dout))
      else $error("gpio mode pin does not follow direction and latch");

   chk_periph_a_drive: assert property ( // [R3]
      ((r_reg.fen & ~r_reg.fsel & A_MAP)
         & ((pad_oe_n ^ ~periph_a_oe) | (pad_out ^ periph_a_out))) == 16'h0000)
      else $error("peripheral a does not own its pins");

   chk_reserved_off: assert property ( // [R7]
      ((~pad_oe_n & r_reg.fen & ((~r_reg.fsel & ~A_MAP) | (r_reg.fsel & ~B_MAP))) == 16'h0000))
      else $error("reserved function drives a pin");

   chk_pull_gate: assert property ( // [R9]
      pull_en == (r_reg.wpu & pad_oe_n))
      else $error("weak pull not tied to buffer off state");

   chk_pull_dir: assert property ( // [R12]
      pull_up == (r_reg.wpu & r_reg.pdr))
      else $error("pull direction wrong");

   chk_wake_match: assert property ( // [R14]
      wake_req == (r_reg.ien & ~(r_reg.pin ^ r_reg.dout)))
      else $error("wake signal does not match latch level");

   chk_wake_path: assert property ( // [R1]
      (r_reg.ien[0] == 1'b0) |-> (wake_in[0] == 1'b0 && wake_req[0] == 1'b0))
      else $error("disabled wake path is active");

   chk_fen_write: assert property ( // [R17]
      s_fen_commit |=> (s_axi_bvalid && r_reg.fen == $past(r_reg.wd[15:0])))
      else $error("function enable write not stored");

   chk_event_sticky: assert property (
      ($rose(wake_req[0])) |=> r_reg.irq_stat[0] [*2])
      else $error("wake event not held in status");

   chk_irq_level: assert property (
      irq == |(r_reg.irq_stat & r_reg.irq_mask))
      else $error("interrupt level wrong");

   chk_reset_vals: assert property (disable iff (1'b0) // [R4] [R11] [R13] [R15] [R16]
      $fell(rst) |-> (r_reg.fen == 16'h0000 && r_reg.wpu == 16'h0000
         && r_reg.pdr == 16'hffff && r_reg.ien == 16'h0000 && r_reg.dir == 16'h0000))
      else $error("reset values wrong");

   chk_bresp_hold: assert property (
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
      else $error("write response dropped early");

   ////////////////////////////////////////////////////////////////////////////////
   // pin-wide and bus timing checks

   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   sequence s_din_ask;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `GPC_OFF_DIN;
   endsequence

   sequence s_stat_clear;
      r_reg.aw_got && r_reg.w_got && r_reg.wa == `GPC_OFF_IRQ_STAT
         && r_reg.ws[0] && r_reg.wd[0];
   endsequence

   sequence s_no_event;
      !(wake_req[0] && !r_reg.wake_prev[0]);
   endsequence

   chk_periph_b_drive: assert property ( // [R3] [R5]
      ((r_reg.fen & r_reg.fsel & B_MAP)
         & ((pad_oe_n ^ ~periph_b_oe) | (pad_out ^ periph_b_out))) == 16'h0000)
      else $error("peripheral b does not own its pins");

   chk_gpio_mixed: assert property ( // [R8]
      ((~r_reg.fen & ((pad_oe_n ^ ~r_reg.dir) | (pad_out ^ r_reg.dout))) == 16'h0000))
      else $error("general-purpose pin disturbed by its neighbours");

   chk_unmapped_in: assert property ( // [R7]
      ((periph_a_in & ~A_MAP) | (periph_b_in & ~B_MAP)) == 16'h0000)
      else $error("reserved entry sees the pin");

   chk_select_gated: assert property ( // [R5]
      ((periph_a_in & r_reg.fsel) | (periph_b_in & ~r_reg.fsel)
         | ((periph_a_in | periph_b_in) & ~r_reg.fen)) == 16'h0000)
      else $error("function select acts while ignored");

   chk_wake_off: assert property ( // [R1]
      ((wake_in | wake_req) & ~r_reg.ien) == 16'h0000)
      else $error("wake path open on a disabled pin");

   chk_pull_up_off: assert property ( // [R12]
      (pull_up & ~r_reg.wpu) == 16'h0000)
      else $error("pull direction shown with pull disabled");

   chk_write_answer: assert property (
      s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");

   chk_read_answer: assert property (
      s_rd_take |=> s_axi_rvalid)
      else $error("read response late");

   chk_din_read: assert property ( // [R2]
      s_din_ask |=> (s_axi_rdata == {16'h0000, $past(r_reg.pin)}))
      else $error("input register does not show the pin");

   chk_busy_refused: assert property (
      !(s_axi_bvalid && (s_axi_awready || s_axi_wready))
         && !(s_axi_rvalid && s_axi_arready))
      else $error("request accepted while a response is pending");

   chk_status_clear: assert property (
      s_stat_clear ##0 s_no_event |=> !r_reg.irq_stat[0])
      else $error("status bit not cleared by writing one");

   chk_set_wins: assert property (
      (wake_req[0] && !r_reg.wake_prev[0]) |=> r_reg.irq_stat[0])
      else $error("wake event lost");

   chk_pin_filter: assert property (
      (r_reg.sync2[0] != r_reg.sync3[0]) |=> $stable(r_reg.pin[0]))
      else $error("pin level taken before the stages agree");

endmodule

// [verilog/gpc_map.svh]
// register offsets, reset values and field layout of the pin configuration port
// assumes a 16-pin port behind an aligned 32-bit register window
//
// What this block does
// R1 - a set wake-input enable bit opens the pin's input path to the wake-up unit, a clear one closes it.
// R2 - with function enable clear the pin is general-purpose i/o driven by direction and output latch.
// R3 - with function enable set the chosen peripheral owns the pin's direction and output value.
// R4 - reset clears every function enable bit so all pins start as general-purpose i/o.
// R5 - function select picks peripheral a at 0 and b at 1 and is ignored while function enable is clear.
// R6 - software keeps function select at 0 for pins without a b-side or without any alternate function.
// R7 - each pin routes to a fixed a or b peripheral signal, and reserved entries connect to nothing.
// R8 - every configuration bit acts on its own pin only.
// R9 - a set weak pull enable turns on the pull whenever the pin's output buffer is off.
// R10 - the weak pull applies in both general-purpose and peripheral mode.
// R11 - reset clears all weak pull enable bits.
// R12 - pull direction selects pulldown at 0 and pullup at 1, and matters only with the pull enabled.
// R13 - reset loads pull direction with all ones so pullups are selected.
// R14 - with wake input enabled a pin raises its wake signal while its level equals its output latch bit.
// R15 - reset clears the wake input enable register.
// R16 - direction 0 makes an input and 1 an output, and reset clears all direction bits.
// R17 - each writable register except irq_stat, where writing one clears a bit, reads back its last written value or its reset value.
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

`define GPC_PINS          16
`define GPC_OFF_FEN       8'h00
`define GPC_OFF_DIR       8'h04
`define GPC_OFF_DIN       8'h08
`define GPC_OFF_DOUT      8'h0c
`define GPC_OFF_WPU       8'h10
`define GPC_OFF_FSEL      8'h18
`define GPC_OFF_IEN       8'h1c
`define GPC_OFF_PDR       8'h20
`define GPC_OFF_IRQ_STAT  8'h24
`define GPC_OFF_IRQ_MASK  8'h28

`define GPC_RST_ZERO      16'h0000
`define GPC_RST_PDR       16'hffff

`define GPC_RESP_OKAY     2'b00
`define GPC_RESP_SLVERR   2'b10

`endif

// [verilog/gpc_pkg.sv]
// types of the pin configuration port; constants live in gpc_map.svh
// assumes the map header is on the include path
`include "gpc_map.svh"

package gpc_pkg;

   typedef logic [`GPC_PINS-1:0] gpc_word_t;

   typedef struct packed {
      gpc_word_t  fen;
      gpc_word_t  fsel;
      gpc_word_t  dir;
      gpc_word_t  dout;
      gpc_word_t  ien;
      gpc_word_t  wpu;
      gpc_word_t  pdr;
      gpc_word_t  irq_stat;
      gpc_word_t  irq_mask;
      gpc_word_t  sync1;
      gpc_word_t  sync2;
      gpc_word_t  sync3;
      gpc_word_t  pin;
      gpc_word_t  wake_prev;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } gpc_state_t;

endpackage

// [tb/gpc_far_end.sv]
// far side of the port: pads with weak pulls and two on-chip peripherals
// assumes the bench drives ext_en/ext_val for outside drivers on the pins
`timescale 1ns/1ps

module gpc_far_end
   import gpc_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire gpc_word_t pad_out,
   input  wire gpc_word_t pad_oe_n,
   input  wire gpc_word_t pull_en,
   input  wire gpc_word_t pull_up,
   input  wire gpc_word_t ext_en,
   input  wire gpc_word_t ext_val,
   output      gpc_word_t pad_in,
   output      gpc_word_t pa_oe,
   output      gpc_word_t pa_out,
   output      gpc_word_t pb_oe,
   output      gpc_word_t pb_out
);
   gpc_word_t last_q = 16'h0000;
   // peripheral a drives all but the top pin, b only alternate nibbles
   assign pa_oe  = 16'h7fff;
   assign pa_out = 16'h00ff;
   assign pb_oe  = 16'h0f0f;
   assign pb_out = 16'h3c3c;
   ////////////////////////////////////////////////////////////////
   // a released pin with no pull shows the inverse of its last level
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pull_en[i]) pad_in[i] = pull_up[i];
         else pad_in[i] = ~last_q[i];
      end
   end
   always @(posedge clk_sys) last_q <= pad_in;
endmodule

// [tb/testbench.sv]
// self-checking bench of the pin configuration port
// assumes gpc_port with pin 0 of peripheral a marked reserved
`timescale 1ns/1ps
`include "gpc_map.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end

module testbench
   import gpc_pkg::*;
;
   logic        clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   gpc_word_t   pad_in, pad_out, oe_n, pull_en, pull_up, ext_en, ext_val;
   gpc_word_t   pa_oe, pa_out, pa_in, pb_oe, pb_out, pb_in, wake_in, wake_req;
   int          err_total, check_count, cyc;

   gpc_port #(.A_MAP(16'hfffe), .B_MAP(16'hffff)) dut (
      .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n), .pull_en(pull_en),
      .pull_up(pull_up), .periph_a_oe(pa_oe), .periph_a_out(pa_out),
      .periph_a_in(pa_in), .periph_b_oe(pb_oe), .periph_b_out(pb_out),
      .periph_b_in(pb_in), .wake_in(wake_in), .wake_req(wake_req), .irq(irq));

   gpc_far_end far (
      .clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(oe_n), .pull_en(pull_en),
      .pull_up(pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in),
      .pa_oe(pa_oe), .pa_out(pa_out), .pb_oe(pb_oe), .pb_out(pb_out));

   ////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ready is sampled mid-cycle, where it is settled, and acted on at the edge
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] p;
      @(posedge clk_sys);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      b = 1'b0;
      while (!b) begin
         @(negedge clk_sys);
         {aw, w, b} = {awvalid && awready, wvalid && wready, bvalid && bready};
         p = bresp;
         @(posedge clk_sys);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      `CHK("bresp", er, p)
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic t, r;
      logic [33:0] dp;
      @(posedge clk_sys);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      r = 1'b0;
      while (!r) begin
         @(negedge clk_sys);
         {t, r} = {arvalid && arready, rvalid && rready};
         dp = {rdata, rresp};
         @(posedge clk_sys);
         if (t) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
      end
      `CHK("rdata", e, dp[33:2])
      `CHK("rresp", er, dp[1:0])
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK("oe_n", 16'hffff, oe_n)
      `CHK("pull_en", 16'h0000, pull_en)
      bus_rd(`GPC_OFF_FEN, 32'h0, `GPC_RESP_OKAY);
      bus_rd(`GPC_OFF_WPU, 32'h0, `GPC_RESP_OKAY);
      bus_rd(`GPC_OFF_PDR, 32'hffff, `GPC_RESP_OKAY);
      bus_rd(`GPC_OFF_IEN, 32'h0, `GPC_RESP_OKAY);
      bus_rd(`GPC_OFF_DIR, 32'h0, `GPC_RESP_OKAY);
   endtask

   task automatic t_regs;
      logic [7:0] o [8] = '{`GPC_OFF_FEN, `GPC_OFF_DIR, `GPC_OFF_DOUT, `GPC_OFF_WPU,
                            `GPC_OFF_FSEL, `GPC_OFF_IEN, `GPC_OFF_PDR, `GPC_OFF_IRQ_MASK};
      for (int i = 0; i < 8; i++) begin
         bus_wr(o[i], 32'hffff0000 | 32'h1111 * (i + 1), `GPC_RESP_OKAY);
         bus_rd(o[i], 32'h1111 * (i + 1), `GPC_RESP_OKAY);
      end
      for (int i = 0; i < 8; i++) bus_wr(o[i], 32'h0, `GPC_RESP_OKAY);
      bus_wr(8'h14, 32'h1, `GPC_RESP_SLVERR);
      bus_rd(8'h14, 32'h0, `GPC_RESP_SLVERR);
   endtask

   task automatic t_gpio;
      bus_wr(`GPC_OFF_DIR, 32'h00ff, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_DOUT, 32'h00a5, `GPC_RESP_OKAY);
      {ext_en, ext_val} <= {16'hff00, 16'h3c00};
      repeat (6) @(posedge clk_sys);
      `CHK("oe_n", 16'hff00, oe_n)
      `CHK("pad_out", 16'h00a5, pad_out & 16'h00ff)
      bus_rd(`GPC_OFF_DIN, 32'h3ca5, `GPC_RESP_OKAY);
      ext_en <= 16'h0000;
   endtask

   task automatic t_alt;
      bus_wr(`GPC_OFF_FEN, 32'hff00, `GPC_RESP_OKAY);
      `CHK("oe_n", 16'h8000, oe_n)
      `CHK("pad_out", 16'h00a5, pad_out)
      bus_wr(`GPC_OFF_FEN, 32'hffff, `GPC_RESP_OKAY);
      repeat (6) @(posedge clk_sys);
      `CHK("oe_n", 16'h8001, oe_n)
      `CHK("pad_out", 16'h00fe, pad_out & 16'hfffe)
      `CHK("pa_in", 16'h00fe, pa_in & 16'h7fff)
      `CHK("pb_in", 16'h0000, pb_in)
      bus_wr(`GPC_OFF_FSEL, 32'hffff, `GPC_RESP_OKAY);
      repeat (6) @(posedge clk_sys);
      `CHK("oe_n", 16'hf0f0, oe_n)
      `CHK("pad_out", 16'h0c0c, pad_out & 16'h0f0f)
      `CHK("pb_in", 16'h0c0c, pb_in & 16'h0f0f)
      `CHK("pa_in", 16'h0000, pa_in)
      bus_wr(`GPC_OFF_FEN, 32'h0, `GPC_RESP_OKAY);
      `CHK("oe_n", 16'hff00, oe_n)
      `CHK("pad_out", 16'h00a5, pad_out & 16'h00ff)
   endtask

   task automatic t_pull;
      bus_wr(`GPC_OFF_WPU, 32'hffff, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_PDR, 32'h0ff0, `GPC_RESP_OKAY);
      `CHK("pull_en", 16'hff00, pull_en)
      `CHK("pull_up", 16'h0ff0, pull_up)
      bus_wr(`GPC_OFF_FEN, 32'hffff, `GPC_RESP_OKAY);
      `CHK("pull_en", 16'hf0f0, pull_en)
      bus_wr(`GPC_OFF_WPU, 32'h00ff, `GPC_RESP_OKAY);
      `CHK("pull_en", 16'h00f0, pull_en)
      `CHK("pull_up", 16'h00f0, pull_up)
   endtask

   task automatic t_wake;
      bus_wr(`GPC_OFF_FEN, 32'h0, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_DIR, 32'h0, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_DOUT, 32'h0001, `GPC_RESP_OKAY);
      {ext_en, ext_val} <= {16'hffff, 16'h0003};
      bus_wr(`GPC_OFF_IRQ_STAT, 32'hffff, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_IEN, 32'h0003, `GPC_RESP_OKAY);
      repeat (6) @(posedge clk_sys);
      `CHK("wake_in", 16'h0003, wake_in)
      `CHK("wake_req", 16'h0001, wake_req)
      `CHK("irq", 1'b0, irq)
      bus_rd(`GPC_OFF_IRQ_STAT, 32'h1, `GPC_RESP_OKAY);
      bus_wr(`GPC_OFF_IRQ_MASK, 32'h0002, `GPC_RESP_OKAY);
      `CHK("irq", 1'b0, irq)
      bus_wr(`GPC_OFF_IRQ_MASK, 32'h0001, `GPC_RESP_OKAY);
      `CHK("irq", 1'b1, irq)
      bus_wr(`GPC_OFF_IRQ_STAT, 32'h0001, `GPC_RESP_OKAY);
      `CHK("irq", 1'b0, irq)
      bus_wr(`GPC_OFF_IEN, 32'h0, `GPC_RESP_OKAY);
      `CHK("wake_in", 16'h0000, wake_in)
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // a hang is cut off far beyond the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      {rst, wstrb} = 5'h1f;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, ext_en, ext_val} = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_regs();
      t_gpio();
      t_alt();
      t_pull();
      t_wake();
      close_out();
   end
endmodule
